/* verilog/wptx_ctrl.sv */
// dual-coil transmitter controller: coil select, probe and power loops
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`include "wptx_map.svh"

module wptx_ctrl #(
    parameter int unsigned PROBE_CYCLES = `WPTX_PROBE_CYC,
    parameter int unsigned GAP_CYCLES   = `WPTX_GAP_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // avalon-mm slave
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // decoded receiver packets
    input  wire logic        pkt_valid,
    input  wire logic [7:0]  pkt_header,
    input  wire logic [7:0]  pkt_data,
    // coil current amplitude in mA
    input  wire logic        cur_valid,
    input  wire logic [11:0] cur_ma,
    // power stage
    output logic             upper_coil_switch,
    output logic             lower_coil_switch,
    output logic             power_on,
    output logic [17:0]      freq_cmd,
    output logic [14:0]      volt_cmd
);

    localparam logic [23:0] DEAD_LAST  = 24'(`WPTX_DEAD_CYC - 1);
    localparam logic [23:0] PROBE_LAST = 24'(PROBE_CYCLES - 1);
    localparam logic [23:0] GAP_LAST   = 24'(GAP_CYCLES - 1);

    wptx_pkg::wptx_state_t state_reg;
    wptx_pkg::wptx_state_t state_next;
    logic [23:0]           timer_reg;
    logic                  coil_reg;
    logic                  failed_reg;
    logic [7:0]            sig_reg;
    logic                  enable_reg;
    logic [11:0]           target_reg;
    logic [11:0]           cur_reg;
    logic                  step_reg;
    logic [17:0]           freq_reg;
    logic [14:0]           volt_reg;
    logic                  sw_upper_reg;
    logic                  sw_lower_reg;
    logic                  power_reg;
    logic [31:0]           rdata_reg;
    logic                  wait_reg;

    logic                  sig_pkt;
    logic                  end_pkt;
    logic                  cerr_pkt;
    logic                  gap_done;
    logic                  can_raise;
    logic                  give_up;
    logic                  bus_wr;
    logic                  bus_rd;
    logic [31:0]           rd_next;
    logic signed [15:0]    err;
    logic signed [15:0]    f_out;
    logic signed [15:0]    v_out;
    logic signed [19:0]    f_sum;
    logic signed [16:0]    v_sum;
    logic [14:0]           v_clamped;
    logic signed [13:0]    tgt_sum;

    assign sig_pkt  = pkt_valid && pkt_header == `WPTX_PKT_SIG_STRENGTH;
    assign end_pkt  = pkt_valid && pkt_header == `WPTX_PKT_END_POWER;
    assign cerr_pkt = pkt_valid && pkt_header == `WPTX_PKT_CTRL_ERROR;
    assign gap_done = state_reg == wptx_pkg::ST_GAP && timer_reg == GAP_LAST;
    assign can_raise =
        volt_reg <= `WPTX_VOLT_MAX - `WPTX_VOLT_RETRY_STEP;
    // both coils tried at the highest voltage that still fits
    assign give_up  = gap_done && coil_reg && !can_raise;
    assign bus_wr   = write && !wait_reg;
    assign bus_rd   = read && wait_reg;

    // probe and transfer sequence
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            wptx_pkg::ST_IDLE: begin
                if (enable_reg && !failed_reg) begin
                    state_next = wptx_pkg::ST_DEAD;
                end
            end
            wptx_pkg::ST_DEAD: begin
                if (!enable_reg) begin
                    state_next = wptx_pkg::ST_IDLE;
                end else if (timer_reg == DEAD_LAST) begin
                    state_next = wptx_pkg::ST_PROBE;
                end
            end
            wptx_pkg::ST_PROBE: begin
                if (!enable_reg) begin
                    state_next = wptx_pkg::ST_IDLE;
                end else if (sig_pkt) begin
                    state_next = wptx_pkg::ST_XFER;
                end else if (timer_reg == PROBE_LAST) begin
                    state_next = wptx_pkg::ST_GAP;
                end
            end
            wptx_pkg::ST_GAP: begin
                if (!enable_reg || give_up) begin
                    state_next = wptx_pkg::ST_IDLE;
                end else if (gap_done) begin
                    state_next = wptx_pkg::ST_DEAD;
                end
            end
            wptx_pkg::ST_XFER: begin
                if (!enable_reg || end_pkt) begin
                    state_next = wptx_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = wptx_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= wptx_pkg::ST_IDLE;
            timer_reg <= 24'h000000;
        end else begin
            state_reg <= state_next;
            if (state_next != state_reg) begin
                timer_reg <= 24'h000000;
            end else begin
                timer_reg <= timer_reg + 24'h000001;
            end
        end
    end

    // upper coil first, then lower; wraps back to upper on a voltage raise
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            coil_reg <= 1'b0;
        end else if (state_reg == wptx_pkg::ST_IDLE) begin
            coil_reg <= 1'b0;
        end else if (gap_done) begin
            coil_reg <= !coil_reg;
        end
    end

    // failure flag: a give-up in the same cycle as a control write wins
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            failed_reg <= 1'b0;
        end else if (give_up) begin
            failed_reg <= 1'b1;
        end else if (bus_wr && address == `WPTX_OFS_CTRL &&
                     byteenable[0]) begin
            failed_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sig_reg <= 8'h00;
        end else if (state_reg == wptx_pkg::ST_PROBE && sig_pkt) begin
            sig_reg <= pkt_data;
        end
    end

    // switches open during dead time, so a coil change never overlaps
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sw_upper_reg <= 1'b0;
            sw_lower_reg <= 1'b0;
            power_reg    <= 1'b0;
        end else begin
            power_reg <= state_next == wptx_pkg::ST_PROBE ||
                         state_next == wptx_pkg::ST_XFER;
            sw_upper_reg <= !coil_reg &&
                            (state_next == wptx_pkg::ST_PROBE ||
                             state_next == wptx_pkg::ST_XFER);
            sw_lower_reg <= coil_reg &&
                            (state_next == wptx_pkg::ST_PROBE ||
                             state_next == wptx_pkg::ST_XFER);
        end
    end

    // current sample, 1 mA per count
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cur_reg <= 12'h000;
        end else if (cur_valid) begin
            cur_reg <= cur_ma;
        end
    end

    // control error packets move the target; the step runs one cycle later
    assign tgt_sum = $signed({2'b00, target_reg}) +
                     14'($signed(pkt_data));
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            target_reg <= `WPTX_TARGET_RST;
            step_reg   <= 1'b0;
        end else begin
            step_reg <= state_reg == wptx_pkg::ST_XFER && cerr_pkt;
            if (state_reg == wptx_pkg::ST_XFER && cerr_pkt) begin
                if (tgt_sum < 14'sh0000) begin
                    target_reg <= 12'h000;
                end else if (tgt_sum > 14'sh0FFF) begin
                    target_reg <= 12'hFFF;
                end else begin
                    target_reg <= tgt_sum[11:0];
                end
            end else if (bus_wr && address == `WPTX_OFS_TARGET) begin
                if (byteenable[0]) begin
                    target_reg[7:0] <= writedata[7:0];
                end
                if (byteenable[1]) begin
                    target_reg[11:8] <= writedata[11:8];
                end
            end
        end
    end

    assign err = $signed({4'h0, target_reg}) - $signed({4'h0, cur_reg});

    wptx_loop_step #(
        .CLAMP (`WPTX_FREQ_CLAMP)
    ) u_freq_loop (
        .err (err),
        .out (f_out)
    );

    wptx_loop_step #(
        .CLAMP (`WPTX_VOLT_CLAMP)
    ) u_volt_loop (
        .err (err),
        .out (v_out)
    );

    // 1 Hz per unit on frequency, -0.5 mV per unit on voltage
    assign f_sum = $signed({2'b00, freq_reg}) + 20'(f_out);
    assign v_sum = $signed({2'b00, volt_reg}) - 17'(v_out);

    always_comb begin
        if (v_sum > $signed({2'b00, `WPTX_VOLT_MAX})) begin
            v_clamped = `WPTX_VOLT_MAX;
        end else if (v_sum < $signed({2'b00, `WPTX_VOLT_MIN})) begin
            v_clamped = `WPTX_VOLT_MIN;
        end else begin
            v_clamped = v_sum[14:0];
        end
    end

    // Hz and 0.5 mV resolution, well under the 0.5 kHz and 50 mV needed
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            freq_reg <= `WPTX_FREQ_PROBE;
            volt_reg <= `WPTX_VOLT_PROBE;
        end else if (state_reg == wptx_pkg::ST_IDLE &&
                     state_next == wptx_pkg::ST_DEAD) begin
            freq_reg <= `WPTX_FREQ_PROBE;
            volt_reg <= `WPTX_VOLT_PROBE;
        end else if (gap_done && coil_reg &&
                     state_next == wptx_pkg::ST_DEAD) begin
            freq_reg <= `WPTX_FREQ_PROBE;
            volt_reg <= volt_reg + `WPTX_VOLT_RETRY_STEP;
        end else if (step_reg && state_reg == wptx_pkg::ST_XFER) begin
            // voltage takes over only when frequency runs out of band
            if (f_sum > $signed({2'b00, `WPTX_FREQ_MAX})) begin
                freq_reg <= `WPTX_FREQ_MAX;
                volt_reg <= v_clamped;
            end else if (f_sum < $signed({2'b00, `WPTX_FREQ_MIN})) begin
                freq_reg <= `WPTX_FREQ_MIN;
                volt_reg <= v_clamped;
            end else begin
                freq_reg <= f_sum[17:0];
            end
        end
    end

    // control register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            enable_reg <= 1'b0;
        end else if (bus_wr && address == `WPTX_OFS_CTRL &&
                     byteenable[0]) begin
            enable_reg <= writedata[`WPTX_CTRL_EN_BIT];
        end
    end

    always_comb begin
        rd_next = 32'h00000000;
        case (address)
            `WPTX_OFS_CTRL: begin
                rd_next[`WPTX_CTRL_EN_BIT] = enable_reg;
            end
            `WPTX_OFS_TARGET: begin
                rd_next[11:0] = target_reg;
            end
            `WPTX_OFS_STATUS: begin
                rd_next[2:0]  = state_reg;
                rd_next[3]    = sw_upper_reg;
                rd_next[4]    = sw_lower_reg;
                rd_next[5]    = failed_reg;
                rd_next[6]    = power_reg;
                rd_next[15:8] = sig_reg;
            end
            `WPTX_OFS_FREQ: begin
                rd_next[17:0] = freq_reg;
            end
            `WPTX_OFS_VOLT: begin
                rd_next[14:0] = volt_reg;
            end
            `WPTX_OFS_CURRENT: begin
                rd_next[11:0] = cur_reg;
            end
            default: begin
                rd_next = 32'h00000000;
            end
        endcase
    end

    // one wait state: request seen, then waitrequest drops for one cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h00000000;
        end else begin
            wait_reg <= !((read || write) && wait_reg);
            if (bus_rd) begin
                rdata_reg <= rd_next;
            end
        end
    end

    assign readdata          = rdata_reg;
    assign waitrequest       = wait_reg;
    assign upper_coil_switch = sw_upper_reg;
    assign lower_coil_switch = sw_lower_reg;
    assign power_on          = power_reg;
    assign freq_cmd          = freq_reg;
    assign volt_cmd          = volt_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_one_coil_only: assert property (
        !(sw_upper_reg && sw_lower_reg))
        else $error("both coil switches closed");

    a_coil_kept: assert property (
        state_reg == wptx_pkg::ST_XFER ##1 state_reg == wptx_pkg::ST_XFER
        |-> $stable(sw_upper_reg) && $stable(sw_lower_reg)
            && (sw_upper_reg ^ sw_lower_reg))
        else $error("coil changed during transfer");

    a_cerr_step: assert property (
        state_reg == wptx_pkg::ST_XFER && cerr_pkt && enable_reg
        |=> step_reg)
        else $error("control error packet gave no loop step");

    a_freq_in_band: assert property (
        freq_reg >= `WPTX_FREQ_MIN && freq_reg <= `WPTX_FREQ_MAX)
        else $error("frequency command out of band");

    a_volt_in_range: assert property (
        volt_reg >= `WPTX_VOLT_MIN && volt_reg <= `WPTX_VOLT_MAX)
        else $error("voltage command out of range");

    a_probe_start_point: assert property (
        state_reg == wptx_pkg::ST_IDLE && state_next == wptx_pkg::ST_DEAD
        |=> freq_reg == `WPTX_FREQ_PROBE && volt_reg == `WPTX_VOLT_PROBE)
        else $error("first probe not at 130 kHz and 8 V");

    a_probe_off_on_miss: assert property (
        state_reg == wptx_pkg::ST_PROBE && timer_reg == PROBE_LAST
        && !sig_pkt |=> !power_reg ##1 !power_reg)
        else $error("power kept after a silent probe");

    a_retry_raises_volt: assert property (
        gap_done && coil_reg && state_next == wptx_pkg::ST_DEAD
        |=> volt_reg == $past(volt_reg) + `WPTX_VOLT_RETRY_STEP
            && freq_reg == `WPTX_FREQ_PROBE)
        else $error("retry did not raise voltage at 130 kHz");

    a_volt_only_at_edge: assert property (
        state_reg == wptx_pkg::ST_XFER && $changed(volt_reg)
        |-> freq_reg == `WPTX_FREQ_MIN || freq_reg == `WPTX_FREQ_MAX)
        else $error("voltage moved inside the frequency band");

    a_current_capture: assert property (
        cur_valid |=> cur_reg == $past(cur_ma))
        else $error("current sample not taken");

    a_freq_step_bound: assert property (
        state_reg == wptx_pkg::ST_XFER ##1 state_reg == wptx_pkg::ST_XFER
        |-> int'(freq_reg) - int'($past(freq_reg)) <= 20000
            && int'($past(freq_reg)) - int'(freq_reg) <= 20000)
        else $error("frequency step beyond clamp");

    a_volt_step_bound: assert property (
        state_reg == wptx_pkg::ST_XFER ##1 state_reg == wptx_pkg::ST_XFER
        |-> int'(volt_reg) - int'($past(volt_reg)) <= 1500
            && int'($past(volt_reg)) - int'(volt_reg) <= 1500)
        else $error("voltage step beyond clamp");

endmodule // wptx_ctrl

/* verilog/wptx_map.svh */
// register map, field positions, limits and timing counts of the controller
`ifndef WPTX_MAP_SVH
`define WPTX_MAP_SVH

// clock and time figures
`define WPTX_CLK_MHZ            20
`define WPTX_DEAD_NS            1000
`define WPTX_DEAD_CYC   ((`WPTX_DEAD_NS * `WPTX_CLK_MHZ + 999) / 1000)
`define WPTX_PROBE_US           70000
`define WPTX_PROBE_CYC  (`WPTX_PROBE_US * `WPTX_CLK_MHZ)
`define WPTX_GAP_US             20000
`define WPTX_GAP_CYC    (`WPTX_GAP_US * `WPTX_CLK_MHZ)

// register byte offsets
`define WPTX_OFS_CTRL           5'h00
`define WPTX_OFS_TARGET         5'h04
`define WPTX_OFS_STATUS         5'h08
`define WPTX_OFS_FREQ           5'h0C
`define WPTX_OFS_VOLT           5'h10
`define WPTX_OFS_CURRENT        5'h14

// fields
`define WPTX_CTRL_EN_BIT        0
`define WPTX_TARGET_RST         12'h1F4

// operating frequency in Hz: 110000, 180000, probe 130000
`define WPTX_FREQ_MIN           18'h1ADB0
`define WPTX_FREQ_MAX           18'h2BF20
`define WPTX_FREQ_PROBE         18'h1FBD0
// inverter input voltage in 0.5 mV units: 5 V, 11 V, probe 8 V, retry 0.5 V
`define WPTX_VOLT_MIN           15'h2710
`define WPTX_VOLT_MAX           15'h55F0
`define WPTX_VOLT_PROBE         15'h3E80
`define WPTX_VOLT_RETRY_STEP    15'h03E8

// loop constants: proportional_gain, integral_gain, derivative_gain
`define WPTX_PROPORTIONAL_GAIN  16'sh0001
`define WPTX_INTEGRAL_GAIN      16'sh0000
`define WPTX_DERIVATIVE_GAIN    16'sh0000
// loop_output_clamp: 20000 (frequency), 1500 (voltage)
`define WPTX_FREQ_CLAMP         16'sh4E20
`define WPTX_VOLT_CLAMP         16'sh05DC

// receiver packet headers
`define WPTX_PKT_SIG_STRENGTH   8'h01
`define WPTX_PKT_END_POWER      8'h02
`define WPTX_PKT_CTRL_ERROR     8'h03

`endif

/* verilog/wptx_pkg.sv */
// types shared by the transmitter controller
package wptx_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEAD,
        ST_PROBE,
        ST_GAP,
        ST_XFER
    } wptx_state_t;

endpackage // wptx_pkg

/* verilog/wptx_loop_step.sv */
// proportional loop step with symmetric output clamp
`timescale 1ns/100ps
`include "wptx_map.svh"

module wptx_loop_step #(
    parameter logic signed [15:0] CLAMP = 16'sh0001
) (
    // error in mA
    input  wire logic signed [15:0] err,
    // clamped loop output
    output logic signed [15:0]      out
);

    logic signed [31:0] prod;

    // integral and derivative gains are zero, so only the p term remains
    always_comb begin
        prod = err * `WPTX_PROPORTIONAL_GAIN;
        if (prod > 32'(CLAMP)) begin
            out = CLAMP;
        end else if (prod < -32'(CLAMP)) begin
            out = -CLAMP;
        end else begin
            out = prod[15:0];
        end
    end

endmodule // wptx_loop_step

/* sim/wptx_rx_model.sv */
// behavioural receiver: answers probes on one coil, sends samples
`timescale 1ns/100ps
`include "wptx_map.svh"
module wptx_rx_model (
    // bench controls
    input  wire logic        clk,
    input  wire logic        ans_lo,
    input  wire logic [14:0] min_v,
    input  wire logic [11:0] cur_set,
    input  wire logic        end_req,
    // transmitter side
    input  wire logic        power_on,
    input  wire logic        upper_coil_switch,
    input  wire logic        lower_coil_switch,
    input  wire logic [14:0] volt_cmd,
    output logic             pkt_valid,
    output logic [7:0]       pkt_header,
    output logic [7:0]       pkt_data,
    output logic             cur_valid,
    output logic [11:0]      cur_ma
);
    logic [3:0] cnt = 4'h0;
    logic       linked = 1'b0;
    wire  logic coupled = (ans_lo ? lower_coil_switch : upper_coil_switch)
                          && volt_cmd >= min_v;
    initial begin
        pkt_valid = 1'b0;
        pkt_header = 8'h00;
        pkt_data = 8'h00;
        cur_valid = 1'b0;
        cur_ma = 12'h000;
    end
    // payload lines toggle between units so stale data never looks valid
    always @(posedge clk) begin
        cnt <= cnt + 4'h1;
        cur_valid <= cnt[2:0] == 3'h0;
        cur_ma <= (cnt[2:0] == 3'h0) ? cur_set : ~cur_ma;
        pkt_valid <= 1'b0;
        pkt_header <= ~pkt_header;
        pkt_data <= ~pkt_data;
        if (!power_on) begin
            linked <= 1'b0;
        end else if (!linked && coupled && cnt == 4'h5) begin
            linked <= 1'b1;
            pkt_valid <= 1'b1;
            pkt_header <= `WPTX_PKT_SIG_STRENGTH;
            pkt_data <= 8'h80;
        end else if (linked && cnt == 4'hF) begin
            pkt_valid <= 1'b1;
            pkt_header <= end_req ? `WPTX_PKT_END_POWER : `WPTX_PKT_CTRL_ERROR;
            pkt_data <= 8'h00;
        end
    end
endmodule // wptx_rx_model

/* sim/wptx_ctrl_test.sv */
// self-checking bench of the transmitter controller
`timescale 1ns/100ps
`include "wptx_map.svh"
module wptx_ctrl_test;
    logic        clk;
    logic        reset_n;
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        pkt_valid;
    logic [7:0]  pkt_header;
    logic [7:0]  pkt_data;
    logic        cur_valid;
    logic [11:0] cur_ma;
    logic        upper_coil_switch;
    logic        lower_coil_switch;
    logic        power_on;
    logic [17:0] freq_cmd;
    logic [14:0] volt_cmd;
    logic        ans_lo;
    logic [14:0] min_v;
    logic [11:0] cur_set;
    logic        end_req;
    logic        po_d;
    logic [31:0] seed;
    logic [17:0] f0;
    logic [14:0] v0;
    int          miscompares;
    int          checked;
    int          n;
    logic [31:0] rq[$];
    logic [15:0] pq[$];

    wptx_ctrl #(.PROBE_CYCLES(40), .GAP_CYCLES(20)) wptx_ctrl_i (
        .clk(clk), .reset_n(reset_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hF),
        .readdata(readdata), .waitrequest(waitrequest),
        .pkt_valid(pkt_valid), .pkt_header(pkt_header),
        .pkt_data(pkt_data), .cur_valid(cur_valid), .cur_ma(cur_ma),
        .upper_coil_switch(upper_coil_switch),
        .lower_coil_switch(lower_coil_switch), .power_on(power_on),
        .freq_cmd(freq_cmd), .volt_cmd(volt_cmd));
    wptx_rx_model wptx_rx_model_i (
        .clk(clk), .ans_lo(ans_lo), .min_v(min_v), .cur_set(cur_set),
        .end_req(end_req),
        .power_on(power_on), .upper_coil_switch(upper_coil_switch),
        .lower_coil_switch(lower_coil_switch), .volt_cmd(volt_cmd),
        .pkt_valid(pkt_valid), .pkt_header(pkt_header),
        .pkt_data(pkt_data), .cur_valid(cur_valid), .cur_ma(cur_ma));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic summarize;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s %0h/%0h", $time, what, got, exp);
        end
    endtask
    task automatic timeout_if(input logic hit);
        if (hit) begin
            chk(32'h1, 32'h0, "timeout");
            summarize();
        end
    endtask
    // one access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        read <= 1'b0;
        write <= 1'b0;
        timeout_if(n >= 50);
        @(posedge clk);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        rq.push_back(exp);
        bus(1'b0, a, 32'h0);
    endtask

    always @(posedge clk) begin
        po_d <= power_on;
        if (read === 1'b1 && waitrequest === 1'b0) begin
            chk(readdata, rq.pop_front(), "read data");
        end
        if (reset_n === 1'b1) begin
            chk({upper_coil_switch & lower_coil_switch,
                 freq_cmd < `WPTX_FREQ_MIN || freq_cmd > `WPTX_FREQ_MAX,
                 volt_cmd < `WPTX_VOLT_MIN || volt_cmd > `WPTX_VOLT_MAX},
                32'h0, "limits");
        end
        if (power_on === 1'b1 && po_d === 1'b0) begin
            chk(freq_cmd, `WPTX_FREQ_PROBE, "probe freq");
            if (pq.size() == 0) begin
                chk(32'h1, 32'h0, "extra probe");
            end else begin
                chk({lower_coil_switch, volt_cmd}, pq.pop_front(),
                    "probe coil");
            end
        end
    end

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        reset_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 5'h00;
        writedata = 32'h0;
        ans_lo = 1'b1;
        min_v = `WPTX_VOLT_PROBE;
        cur_set = 12'h1F4;
        end_req = 1'b0;
        seed = 32'hFBBE;
        po_d = 1'b0;
        miscompares = 0;
        checked = 0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        // upper coil stays silent, lower answers at the opening voltage
        pq.push_back({1'b0, `WPTX_VOLT_PROBE});
        pq.push_back({1'b1, `WPTX_VOLT_PROBE});
        bus(1'b1, `WPTX_OFS_CTRL, 32'h1);
        for (n = 0; n < 600 && !(lower_coil_switch === 1'b1 &&
             pq.size() == 0); n++) @(posedge clk);
        timeout_if(n == 600);
        repeat (10) @(posedge clk);
        rd(`WPTX_OFS_STATUS, 32'h8054);
        rd(5'h18, 32'h0);
        bus(1'b1, `WPTX_OFS_FREQ, 32'h0);
        rd(`WPTX_OFS_FREQ, 32'h1FBD0);
        rd(`WPTX_OFS_CURRENT, 32'h1F4);
        $display("probe and registers done");
        seed = xs(seed);
        cur_set <= 12'h12C + {5'h00, seed[6:0]};
        f0 = freq_cmd;
        for (n = 0; n < 200 && freq_cmd === f0; n++) @(posedge clk);
        timeout_if(n == 200);
        chk(freq_cmd, 32'(f0) + 32'h1F4 - 32'(cur_set), "step");
        $display("proportional step done");
        bus(1'b1, `WPTX_OFS_TARGET, 32'hFFF);
        cur_set <= 12'h000;
        for (n = 0; n < 3000 && freq_cmd !== `WPTX_FREQ_MAX; n++)
            @(posedge clk);
        timeout_if(n == 3000);
        v0 = volt_cmd;
        for (n = 0; n < 200 && volt_cmd === v0; n++) @(posedge clk);
        timeout_if(n == 200);
        chk(volt_cmd, 32'(v0) - 32'h5DC, "volt step");
        for (n = 0; n < 300 && volt_cmd !== `WPTX_VOLT_MIN; n++)
            @(posedge clk);
        timeout_if(n == 300);
        chk(freq_cmd, `WPTX_FREQ_MAX, "freq edge");
        $display("band edge done");
        bus(1'b1, `WPTX_OFS_CTRL, 32'h0);
        ans_lo <= 1'b0;
        min_v <= 15'h4268;
        cur_set <= 12'h1F4;
        // both coils fail at 8 V, upper answers after one voltage rise
        pq.push_back({1'b0, `WPTX_VOLT_PROBE});
        pq.push_back({1'b1, `WPTX_VOLT_PROBE});
        pq.push_back({1'b0, 15'h4268});
        bus(1'b1, `WPTX_OFS_CTRL, 32'h1);
        for (n = 0; n < 1000 && pq.size() != 0; n++) @(posedge clk);
        timeout_if(n == 1000);
        repeat (60) @(posedge clk);
        chk({power_on, upper_coil_switch}, 32'h3, "kept");
        $display("retry done");
        // receiver ends power, then no coil answers at any level
        end_req <= 1'b1;
        min_v <= 15'h7FFF;
        v0 = `WPTX_VOLT_PROBE;
        while (v0 <= `WPTX_VOLT_MAX) begin
            pq.push_back({1'b0, v0});
            pq.push_back({1'b1, v0});
            v0 = v0 + `WPTX_VOLT_RETRY_STEP;
        end
        for (n = 0; n < 1500 && pq.size() != 0; n++) @(posedge clk);
        timeout_if(n == 1500);
        repeat (80) @(posedge clk);
        rd(`WPTX_OFS_STATUS, 32'h8020);
        // a control write clears the failed flag and probes afresh
        pq.push_back({1'b0, `WPTX_VOLT_PROBE});
        bus(1'b1, `WPTX_OFS_CTRL, 32'h1);
        for (n = 0; n < 100 && pq.size() != 0; n++) @(posedge clk);
        timeout_if(n == 100);
        $display("give up done");
        summarize();
    end
endmodule // wptx_ctrl_test
